// ===== verilog/coc_clock_output_control.sv
// clock output control: serial registers, pin control, output gating
`timescale 1ns/1ns
module coc_clock_output_control
	import coc_pkg::*;
#(
	parameter int N_OUT = 6,
	parameter int N_DIV = 5
) (
	input  wire logic                    mclk_i,
	input  wire logic                    rst_i,
	input  wire logic                    ce_i,
	input  wire logic                    oclk_i,
	input  wire logic                    scl_i,
	input  wire logic                    sda_i,
	output logic                         sda_o,
	output logic                         sda_oe_o,
	input  wire logic                    addr_sel_pin_i,
	input  wire logic                    output_enable_low_pin_i,
	input  wire logic [1:0]              spread_enable_pins_i,
	input  wire logic [N_DIV-1:0]        int_divider_freq_select_i,
	input  wire logic [1:0]              frac_synth_freq_select_i,
	input  wire logic [1:0]              ref_input_select_i,
	input  wire logic [2:0]              ref_present_i,
	input  wire logic [3:0]              profile_select_i,
	output logic [N_OUT-1:0]             clk_out_true_pin_o,
	output logic [N_OUT-1:0]             clk_out_comp_pin_o,
	output logic [N_OUT-1:0][2:0]        skew_code_o,
	output logic [1:0]                   spread_enable_synth_o,
	output coc_ss_cfg_t [1:0]            spread_cfg_o,
	output logic [1:0]                   frac_synth_profile_o,
	output logic [N_DIV-1:0][7:0]        integer_divider_n_o,
	output logic [1:0]                   ref_select_o,
	output logic                         outputs_started_o,
	output logic [3:0]                   profile_o
);

	// ==========================================================
	// parameter checks
	if (N_OUT < 1 || N_OUT > MAX_OUT) begin : g_chk_out
		$error("N_OUT must be 1 to 8");
	end
	if (N_DIV < 1 || N_DIV > MAX_OUT) begin : g_chk_div
		$error("N_DIV must be 1 to 8");
	end

	// ==========================================================
	// functions
	function automatic logic [7:0] reset_value(input int a);
		reset_value = RST_OTHER;
		if (a == int'(ADDR_OUT_EN)) begin
			reset_value = RST_OUT_EN;
		end else if (a == int'(ADDR_OE_SCOPE)) begin
			reset_value = RST_OE_SCOPE;
		end else if (a == int'(ADDR_REF_CFG)) begin
			reset_value = RST_REF_CFG;
		end else if (a == int'(ADDR_SS0) || a == int'(ADDR_SS1)) begin
			reset_value = RST_SS;
		end else if (a >= int'(ADDR_DIV_A) && a < int'(ADDR_DIV_B)) begin
			reset_value = RST_DIV_A;
		end else if (a >= int'(ADDR_DIV_B)) begin
			reset_value = RST_DIV_B;
		end
	endfunction

	// clamp a written byte to what its register can hold
	function automatic logic [7:0] fit_value(input logic [7:0] a, input logic [7:0] d);
		logic [4:0] mag;
		mag = d[4:0];
		fit_value = d;
		if (a >= ADDR_SKEW && a < ADDR_DIV_A) begin
			fit_value = {5'h00, d[2:0]}; // R5
		end else if (a >= ADDR_DIV_A) begin
			fit_value = (d < DIV_MIN) ? DIV_MIN : d; // R12
		end else if (a == ADDR_SS0 || a == ADDR_SS1) begin
			if (mag < SS_MAG_MIN) begin
				mag = SS_MAG_MIN;
			end else if (mag > SS_MAG_MAX) begin
				mag = SS_MAG_MAX;
			end
			fit_value = {d[SS_DOWN_BIT], 2'b00, mag}; // R7
		end
	endfunction

	// ==========================================================
	// pin synchronisers, main clock
	localparam int PW = 16 + N_DIV;

	logic [PW-1:0]    pin_raw;
	logic [PW-1:0]    pin_s1;
	logic [PW-1:0]    pin_s2;
	logic             scl_s;
	logic             sda_s;
	logic             addr_sel_s;
	logic [1:0]       ss_pin_s;
	logic [N_DIV-1:0] fs_int_s;
	logic [1:0]       fs_ms_s;
	logic [1:0]       ref_sel_pin_s;
	logic [2:0]       ref_present_s;
	logic [3:0]       profile_s;

	assign pin_raw = {scl_i, sda_i, addr_sel_pin_i, spread_enable_pins_i,
		int_divider_freq_select_i, frac_synth_freq_select_i, ref_input_select_i,
		ref_present_i, profile_select_i};
	assign {scl_s, sda_s, addr_sel_s, ss_pin_s, fs_int_s, fs_ms_s, ref_sel_pin_s,
		ref_present_s, profile_s} = pin_s2;

	always_ff @(posedge mclk_i) begin
		if (ce_i) begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
		end
	end

	// ==========================================================
	// serial slave
	logic [7:0]   regs [REG_COUNT];
	coc_i2c_st_t  st;
	coc_i2c_st_t  ack_to;
	logic [3:0]   bitcnt;
	logic [7:0]   shreg;
	logic [7:0]   ptr;
	logic         sda_low;
	logic         wr_stb;
	logic [7:0]   wr_addr;
	logic [7:0]   wr_data;
	logic         scl_q;
	logic         sda_q;
	logic         i2c_start;
	logic         i2c_stop;
	logic         scl_rise;
	logic         scl_fall;
	logic [6:0]   dev_addr;
	logic [7:0]   rd_now;
	logic [7:0]   status;
	logic         ref_ok;
	logic         started;
	logic [1:0]   eff_sel;

	assign dev_addr  = {I2C_BASE_ADDR[6:1], addr_sel_s}; // R17
	assign i2c_start = scl_s & scl_q & sda_q & ~sda_s;
	assign i2c_stop  = scl_s & scl_q & ~sda_q & sda_s;
	assign scl_rise  = scl_s & ~scl_q;
	assign scl_fall  = ~scl_s & scl_q;
	assign sda_o     = 1'b0;
	assign sda_oe_o  = sda_low;
	assign status    = {profile_s, 2'b00, started, ref_ok};
	assign rd_now    = (ptr == ADDR_STATUS) ? status :
		(ptr < ADDR_STATUS) ? regs[ptr[4:0]] : 8'h00;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (ce_i) begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	// standard write: address, pointer, data...; read from pointer
	always_ff @(posedge mclk_i) begin // R21
		if (rst_i) begin
			st      <= ST_IDLE;
			ack_to  <= ST_IDLE;
			bitcnt  <= 4'h0;
			shreg   <= 8'h00;
			ptr     <= 8'h00;
			sda_low <= 1'b0;
			wr_stb  <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 8'h00;
		end else if (ce_i) begin
			wr_stb <= 1'b0;
			if (i2c_stop) begin
				st      <= ST_IDLE;
				sda_low <= 1'b0;
			end else if (i2c_start) begin
				st      <= ST_ADDR;
				bitcnt  <= 4'h0;
				sda_low <= 1'b0;
			end else begin
				unique case (st)
					ST_IDLE: begin
					end
					ST_ADDR, ST_PTR, ST_WDATA: begin
						if (scl_rise) begin
							shreg  <= {shreg[6:0], sda_s};
							bitcnt <= bitcnt + 4'h1;
						end else if (scl_fall && bitcnt == 4'h8) begin
							bitcnt <= 4'h0;
							if (st == ST_ADDR) begin
								if (shreg[7:1] == dev_addr) begin // R17
									sda_low <= 1'b1;
									st      <= ST_ACK;
									ack_to  <= shreg[0] ? ST_RDATA : ST_PTR;
								end else begin
									st <= ST_IDLE;
								end
							end else begin
								sda_low <= 1'b1;
								st      <= ST_ACK;
								ack_to  <= ST_WDATA;
								if (st == ST_PTR) begin
									ptr <= shreg;
								end else begin
									wr_stb  <= 1'b1;
									wr_addr <= ptr;
									wr_data <= shreg;
									ptr     <= ptr + 8'h01;
								end
							end
						end
					end
					ST_ACK, ST_RACK: begin
						if (st == ST_RACK && scl_rise && sda_s) begin
							st <= ST_IDLE;
						end else if (scl_fall) begin
							if (st == ST_RACK || ack_to == ST_RDATA) begin
								shreg   <= {rd_now[6:0], 1'b0};
								sda_low <= ~rd_now[7];
								bitcnt  <= 4'h1;
								ptr     <= ptr + 8'h01;
								st      <= ST_RDATA;
							end else begin
								sda_low <= 1'b0;
								st      <= ack_to;
							end
						end
					end
					ST_RDATA: begin
						if (scl_fall) begin
							if (bitcnt == 4'h8) begin
								sda_low <= 1'b0;
								st      <= ST_RACK;
							end else begin
								sda_low <= ~shreg[7];
								shreg   <= {shreg[6:0], 1'b0};
								bitcnt  <= bitcnt + 4'h1;
							end
						end
					end
					default: begin
						st <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// volatile register file, reloaded from stored values at reset
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs[i] <= reset_value(i); // R20
			end
		end else if (ce_i && wr_stb && wr_addr < ADDR_STATUS) begin
			regs[wr_addr[4:0]] <= fit_value(wr_addr, wr_data); // R22
		end
	end

	// ==========================================================
	// reference selection and start gate
	assign eff_sel = regs[int'(ADDR_REF_CFG)][REF_PIN_MODE_BIT] ? ref_sel_pin_s // R23
		: regs[int'(ADDR_REF_CFG)][1:0];
	assign ref_ok  = (eff_sel == 2'b11) ? 1'b0 : ref_present_s[eff_sel];

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			started <= 1'b0;
		end else if (ce_i && ref_ok) begin
			started <= 1'b1; // R24
		end
	end

	// ==========================================================
	// registered control outputs
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			ref_select_o          <= 2'b00;
			outputs_started_o     <= 1'b0;
			profile_o             <= 4'h0;
			spread_enable_synth_o <= 2'b00;
			frac_synth_profile_o  <= 2'b00;
			spread_cfg_o          <= '0;
			skew_code_o           <= '0;
			integer_divider_n_o   <= '0;
		end else if (ce_i) begin
			ref_select_o          <= eff_sel; // R18
			outputs_started_o     <= started;
			profile_o             <= profile_s; // R19
			spread_enable_synth_o <= ss_pin_s; // R9
			frac_synth_profile_o  <= fs_ms_s; // R13
			for (int k = 0; k < 2; k++) begin
				spread_cfg_o[k].down       <= regs[int'(ADDR_SS0) + k][SS_DOWN_BIT]; // R8
				spread_cfg_o[k].mag_tenths <= regs[int'(ADDR_SS0) + k][4:0]; // R7
			end
			for (int i = 0; i < N_OUT; i++) begin
				skew_code_o[i] <= regs[int'(ADDR_SKEW) + i][2:0]; // R5
			end
			for (int i = 0; i < N_DIV; i++) begin
				integer_divider_n_o[i] <= fs_int_s[i] ? regs[int'(ADDR_DIV_B) + i] // R11
					: regs[int'(ADDR_DIV_A) + i];
			end
		end
	end

	// ==========================================================
	// per-output configuration, main clock side
	coc_out_cfg_t [N_OUT-1:0] cfg_m;

	always_comb begin
		for (int i = 0; i < N_OUT; i++) begin
			cfg_m[i].soft_en  = regs[int'(ADDR_OUT_EN)][i];
			cfg_m[i].se_mode  = regs[int'(ADDR_SE_MODE)][i];
			cfg_m[i].pol_true = regs[int'(ADDR_POL_TRUE)][i];
			cfg_m[i].pol_comp = regs[int'(ADDR_POL_COMP)][i];
			cfg_m[i].oe_scope = regs[int'(ADDR_OE_SCOPE)][i];
		end
	end

	// ==========================================================
	// output clock domain crossings
	coc_out_cfg_t [N_OUT-1:0] cfg_o1;
	coc_out_cfg_t [N_OUT-1:0] cfg_o2;
	logic                     start_o1;
	logic                     start_o2;
	logic                     oe_o1;
	logic                     oe_o2;
	logic                     ce_o1;
	logic                     ce_o2;
	logic                     orst1;
	logic                     orst2;

	always_ff @(posedge oclk_i) begin
		ce_o1 <= ce_i;
		ce_o2 <= ce_o1;
		orst1 <= rst_i;
		orst2 <= orst1;
	end

	// quasi-static config and pin level resynchronised here
	always_ff @(posedge oclk_i) begin
		if (ce_o2) begin
			cfg_o1   <= cfg_m;
			cfg_o2   <= cfg_o1;
			start_o1 <= started;
			start_o2 <= start_o1;
			oe_o1    <= output_enable_low_pin_i; // R25
			oe_o2    <= oe_o1;
		end
	end

	// ==========================================================
	// output gating, changes only after a full period
	logic             ophase;
	logic [N_OUT-1:0] run;
	logic [N_OUT-1:0] next_run;
	logic [N_OUT-1:0] next_true;
	logic [N_OUT-1:0] next_comp;
	logic [N_OUT-1:0] gate;

	always_comb begin
		for (int i = 0; i < N_OUT; i++) begin
			next_run[i]  = start_o2 & cfg_o2[i].soft_en // R4
				& ~(cfg_o2[i].oe_scope & oe_o2); // R3 R14
			gate[i]      = ophase ? next_run[i] : run[i]; // R6
			next_true[i] = gate[i] & (~ophase ^ cfg_o2[i].pol_true); // R2
			next_comp[i] = gate[i] & (cfg_o2[i].se_mode ? // R1
				(~ophase ^ cfg_o2[i].pol_comp) : ~(~ophase ^ cfg_o2[i].pol_true));
		end
	end

	always_ff @(posedge oclk_i) begin
		if (orst2) begin
			ophase <= 1'b0;
			run    <= '0;
		end else if (ce_o2) begin
			ophase <= ~ophase;
			if (ophase) begin
				run <= next_run; // R15
			end
		end
	end

	always_ff @(posedge oclk_i) begin
		if (orst2) begin
			clk_out_true_pin_o <= '0;
			clk_out_comp_pin_o <= '0;
		end else if (ce_o2) begin
			clk_out_true_pin_o <= next_true; // R16
			clk_out_comp_pin_o <= next_comp; // R16
		end
	end

endmodule

// ===== verilog/coc_pkg.sv
// constants, types and register map of the clock output control block
// Behaviour
// R1: single-ended mode drives both pins, in phase
// R2: per-pin polarity on true and complement pins
// R3: enable-low pin high disables designated outputs
// R4: soft enable bit disables output regardless of pin
// R5: per-output skew, 35 ps steps over 245 ps
// R6: enable changes only at period boundaries
// R7: centre or down spread, 0.1 to 2.5 percent
// R8: independent spread per fractional synthesizer
// R9: spread pin level enables spread immediately
// R10: host sets PCIe spread to 33 kHz, -0.5%
// R11: divider select pin picks value A or B
// R12: divider values limited to 8 through 255
// R13: synth select pin switches frequency or profile
// R14: enable pin scope: one, bank or all outputs
// R15: stop within 2-6 cycles, clean within 20 us
// R16: pin pair gated together, glitch free
// R17: address pin sets slave address bit zero
// R18: input select pins choose reference input
// R19: up to sixteen profiles by select pins
// R20: stored configuration runs clocks without host
// R21: serial port is an I2C slave
// R22: serial writes touch only volatile registers
// R23: config bit picks pin or register input select
// R24: no reference clock at start keeps outputs off
// R25: pin levels synchronised into output clock domain
package coc_pkg;

	// ==========================================================
	// serial port
	localparam logic [6:0] I2C_BASE_ADDR = 7'h53;

	// ==========================================================
	// register addresses
	localparam logic [7:0] ADDR_OUT_EN   = 8'h00;
	localparam logic [7:0] ADDR_SE_MODE  = 8'h01;
	localparam logic [7:0] ADDR_POL_TRUE = 8'h02;
	localparam logic [7:0] ADDR_POL_COMP = 8'h03;
	localparam logic [7:0] ADDR_OE_SCOPE = 8'h04;
	localparam logic [7:0] ADDR_REF_CFG  = 8'h05;
	localparam logic [7:0] ADDR_SS0      = 8'h06;
	localparam logic [7:0] ADDR_SS1      = 8'h07;
	localparam logic [7:0] ADDR_SKEW     = 8'h08;
	localparam logic [7:0] ADDR_DIV_A    = 8'h10;
	localparam logic [7:0] ADDR_DIV_B    = 8'h18;
	localparam logic [7:0] ADDR_STATUS   = 8'h20;
	localparam int         REG_COUNT     = 32;
	localparam int         MAX_OUT       = 8;

	// ==========================================================
	// field positions
	localparam int REF_PIN_MODE_BIT = 7;
	localparam int SS_DOWN_BIT      = 7;

	// ==========================================================
	// reset values (stored configuration)
	localparam logic [7:0] RST_OUT_EN   = 8'hFF;
	localparam logic [7:0] RST_OE_SCOPE = 8'hFF;
	localparam logic [7:0] RST_REF_CFG  = 8'h80;
	localparam logic [7:0] RST_SS       = 8'h85;
	localparam logic [7:0] RST_DIV_A    = 8'h0A;
	localparam logic [7:0] RST_DIV_B    = 8'h14;
	localparam logic [7:0] RST_OTHER    = 8'h00;

	// ==========================================================
	// limits
	localparam logic [7:0] DIV_MIN      = 8'h08;
	localparam logic [4:0] SS_MAG_MIN   = 5'h01;
	localparam logic [4:0] SS_MAG_MAX   = 5'h19;
	localparam int         SKEW_STEP_PS = 35;
	localparam int         SKEW_SPAN_PS = 245;
	localparam int         SKEW_STEPS   = SKEW_SPAN_PS / SKEW_STEP_PS;
	localparam int         SS_MAX_MHZ   = 250;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK
	} coc_i2c_st_t;

	typedef struct packed {
		logic soft_en;
		logic se_mode;
		logic pol_true;
		logic pol_comp;
		logic oe_scope;
	} coc_out_cfg_t;

	typedef struct packed {
		logic       down;
		logic [4:0] mag_tenths;
	} coc_ss_cfg_t;

endpackage

// ===== tb/coc_checker.sv
// assertion checker for the clock output control block
`timescale 1ns/1ns
module coc_checker
	import coc_pkg::*;
#(
	parameter int N_OUT = 6,
	parameter int N_DIV = 5
) (
	input wire logic                  mclk_i,
	input wire logic                  rst_i,
	input wire logic                  oclk_i,
	input wire logic                  scl_i,
	input wire logic                  sda_oe_o,
	input wire logic                  output_enable_low_pin_i,
	input wire logic [1:0]            spread_enable_pins_i,
	input wire logic [1:0]            frac_synth_freq_select_i,
	input wire logic [3:0]            profile_select_i,
	input wire logic [N_OUT-1:0]      clk_out_true_pin_o,
	input wire logic [N_OUT-1:0]      clk_out_comp_pin_o,
	input wire logic [1:0]            spread_enable_synth_o,
	input wire coc_ss_cfg_t [1:0]     spread_cfg_o,
	input wire logic [1:0]            frac_synth_profile_o,
	input wire logic [N_DIV-1:0][7:0] integer_divider_n_o,
	input wire logic                  outputs_started_o,
	input wire logic [3:0]            profile_o
);
	// ==========================================================
	// helper counters
	logic [3:0] since;
	logic [7:0] off_cnt;
	always_ff @(posedge mclk_i) begin
		if (rst_i) since <= 4'h0;
		else if (since != 4'hF) since <= since + 4'h1;
	end
	always_ff @(posedge mclk_i) begin
		if (rst_i || outputs_started_o) off_cnt <= 8'h00;
		else if (off_cnt != 8'hFF) off_cnt <= off_cnt + 8'h01;
	end

	// ==========================================================
	// assertions
	a_spread_follow: assert property (@(posedge mclk_i) disable iff (rst_i)
		since == 4'hF |-> spread_enable_synth_o == $past(spread_enable_pins_i, 3))
		else $error("spread enable does not follow its pins");
	a_synth_select: assert property (@(posedge mclk_i) disable iff (rst_i)
		since == 4'hF |-> frac_synth_profile_o == $past(frac_synth_freq_select_i, 3))
		else $error("synth profile does not follow its pins");
	a_profile_follow: assert property (@(posedge mclk_i) disable iff (rst_i)
		since == 4'hF |-> profile_o == $past(profile_select_i, 3))
		else $error("profile does not follow its pins");
	a_div_floor: assert property (@(posedge mclk_i) disable iff (rst_i)
		since == 4'hF |-> integer_divider_n_o[0] >= DIV_MIN
			&& integer_divider_n_o[N_DIV-1] >= DIV_MIN)
		else $error("divider value below floor");
	a_spread_range: assert property (@(posedge mclk_i) disable iff (rst_i)
		since == 4'hF |-> spread_cfg_o[0].mag_tenths inside {[SS_MAG_MIN:SS_MAG_MAX]}
			&& spread_cfg_o[1].mag_tenths inside {[SS_MAG_MIN:SS_MAG_MAX]})
		else $error("spread magnitude out of range");
	a_outputs_off: assert property (@(posedge mclk_i) disable iff (rst_i)
		off_cnt >= 8'h80 |-> clk_out_true_pin_o == '0 && clk_out_comp_pin_o == '0)
		else $error("outputs run without a reference");
	a_stop_bound: assert property (@(posedge oclk_i) disable iff (rst_i)
		output_enable_low_pin_i [*5] |-> !clk_out_true_pin_o[0] && !clk_out_comp_pin_o[0])
		else $error("output not stopped after enable pin went high");
	a_sda_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
		(since == 4'hF && scl_i) [*6] |-> $stable(sda_oe_o))
		else $error("data line changed while serial clock high");
endmodule

// ===== tb/coc_i2c_host.sv
// serial host model driving the control port
`timescale 1ns/1ns
module coc_i2c_host (
	input  wire logic mclk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic qtr(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	// data moves mid low phase, sampled at end of high phase
	task automatic bit_x(input logic b, output logic r);
		qtr(4);
		sda_low_o = ~b;
		qtr(4);
		scl_o = 1'b1;
		qtr(8);
		r = sda_i;
		scl_o = 1'b0;
	endtask
	task automatic start();
		qtr(4);
		sda_low_o = 1'b0;
		qtr(4);
		scl_o = 1'b1;
		qtr(8);
		sda_low_o = 1'b1;
		qtr(8);
		scl_o = 1'b0;
	endtask
	task automatic stop();
		qtr(4);
		sda_low_o = 1'b1;
		qtr(4);
		scl_o = 1'b1;
		qtr(8);
		sda_low_o = 1'b0;
		qtr(8);
	endtask
	task automatic tx(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(v[i], r);
		bit_x(1'b1, r);
		ack = ~r;
	endtask
	task automatic write(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d,
			output logic ok);
		logic a0, a1, a2;
		start();
		tx({dev, 1'b0}, a0);
		tx(p, a1);
		tx(d, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask
	// single byte read, ended with a not-acknowledge
	task automatic read(input logic [6:0] dev, input logic [7:0] p, output logic [7:0] d,
			output logic ok);
		logic a0, a1, a2, r;
		start();
		tx({dev, 1'b0}, a0);
		tx(p, a1);
		start();
		tx({dev, 1'b1}, a2);
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(1'b1, r);
		stop();
		ok = a0 & a1 & a2;
	endtask
endmodule

// ===== tb/coc_clock_output_control_tb_top.sv
// testbench for the clock output control block
`timescale 1ns/1ns
module coc_clock_output_control_tb_top
	import coc_pkg::*;
;
	localparam int N_OUT = 6;
	localparam int N_DIV = 5;
	localparam logic [7:0] RTAB [9] = '{RST_OUT_EN, RST_OTHER, RST_OTHER, RST_OTHER,
		RST_OE_SCOPE, RST_REF_CFG, RST_SS, RST_SS, RST_OTHER};
	localparam logic [7:0] SS_W [4] = '{8'h1F, 8'h00, 8'h19, 8'h81};
	localparam logic [7:0] SS_E [4] = '{8'h19, 8'h01, 8'h19, 8'h21};
	logic mclk = 1'b0;
	logic oclk = 1'b0;
	logic rst = 1'b1;
	logic scl, sda_low, sda_oe, started;
	wire  sda_line;
	logic addr_sel = 1'b1;
	logic oe_low = 1'b0;
	logic [1:0] ss_pin = 2'b00;
	logic [1:0] fs_ms = 2'b00;
	logic [1:0] ref_sel = 2'b00;
	logic [2:0] ref_pres = 3'b000;
	logic [3:0] prof = 4'h0;
	logic [N_DIV-1:0] fs_int = '0;
	logic [N_OUT-1:0] t_o, c_o;
	logic [N_OUT-1:0][2:0] skew;
	logic [1:0] ss_o, fsp, rsel;
	coc_ss_cfg_t [1:0] ss_cfg;
	logic [N_DIV-1:0][7:0] div_n;
	logic [3:0] prof_o;
	logic [7:0] v;
	logic ok;
	int error_cnt = 0;
	int check_count = 0;

	always #2 mclk = ~mclk;
	initial begin
		#7;
		forever #32 oclk = ~oclk;
	end
	assign sda_line = ~(sda_low | sda_oe);

	coc_i2c_host host (.mclk_i(mclk), .sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low));
	coc_clock_output_control #(.N_OUT(N_OUT), .N_DIV(N_DIV)) dut (
		.mclk_i(mclk), .rst_i(rst), .ce_i(1'b1), .oclk_i(oclk), .scl_i(scl),
		.sda_i(sda_line), .sda_o(), .sda_oe_o(sda_oe), .addr_sel_pin_i(addr_sel),
		.output_enable_low_pin_i(oe_low), .spread_enable_pins_i(ss_pin),
		.int_divider_freq_select_i(fs_int), .frac_synth_freq_select_i(fs_ms),
		.ref_input_select_i(ref_sel), .ref_present_i(ref_pres), .profile_select_i(prof),
		.clk_out_true_pin_o(t_o), .clk_out_comp_pin_o(c_o), .skew_code_o(skew),
		.spread_enable_synth_o(ss_o), .spread_cfg_o(ss_cfg), .frac_synth_profile_o(fsp),
		.integer_divider_n_o(div_n), .ref_select_o(rsel), .outputs_started_o(started),
		.profile_o(prof_o));

	// ==========================================================
	// tasks
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.write({I2C_BASE_ADDR[6:1], addr_sel}, a, d, ok);
		check({7'h0, ok}, 8'h01);
		repeat (4) @(negedge mclk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		host.read({I2C_BASE_ADDR[6:1], addr_sel}, a, d, ok);
		check({7'h0, ok}, 8'h01);
	endtask
	task automatic do_reset();
		rst = 1'b1;
		repeat (64) @(negedge mclk);
		rst = 1'b0;
		repeat (12) @(negedge mclk);
	endtask
	task automatic wait_start();
		int n;
		n = 0;
		while (started !== 1'b1 && n < 2000) begin
			@(negedge mclk);
			n++;
		end
		if (n == 2000) begin
			error_cnt++;
			test_done();
		end
	endtask
	// running: true pin high at least once, comp in phase or inverse; stopped: both low
	task automatic out_chk(input int i, input logic run, input logic inph);
		logic hi, bad;
		hi = 1'b0;
		bad = 1'b0;
		repeat (10) @(negedge oclk);
		repeat (4) begin
			@(negedge oclk);
			hi |= t_o[i];
			if (run) bad |= (c_o[i] !== (inph ? t_o[i] : ~t_o[i]));
			else bad |= ((t_o[i] | c_o[i]) !== 1'b0);
		end
		check({7'h0, hi}, {7'h0, run});
		check({7'h0, bad}, 8'h00);
		@(negedge mclk);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		do_reset();
		repeat (300) @(negedge mclk);
		check({7'h0, started}, 8'h00);
		out_chk(0, 1'b0, 1'b0);
		ref_pres = 3'b001;
		wait_start();
		out_chk(0, 1'b1, 1'b0);
		for (int i = 0; i < 9; i++) begin
			rd(8'(i), v);
			check(v, RTAB[i]);
		end
		rd(ADDR_DIV_A, v);
		check(v, RST_DIV_A);
		rd(ADDR_DIV_B, v);
		check(v, RST_DIV_B);
		for (int i = 0; i < 4; i++) begin
			ss_pin = 2'(i);
			fs_ms = 2'(3 - i);
			prof = 4'(5 * i);
			repeat (4) @(negedge mclk);
			check({6'h0, ss_o}, 8'(i));
			check({6'h0, fsp}, 8'(3 - i));
			check({4'h0, prof_o}, 8'(5 * i));
		end
		rd(ADDR_STATUS, v);
		check(v, 8'hF3);
		wr(ADDR_STATUS, 8'h00);
		rd(ADDR_STATUS, v);
		check(v, 8'hF3);
		rd(8'h21, v);
		check(v, 8'h00);
		addr_sel = 1'b0;
		repeat (4) @(negedge mclk);
		wr(ADDR_SE_MODE, 8'h00);
		host.write(I2C_BASE_ADDR, ADDR_SE_MODE, 8'h55, ok);
		check({7'h0, ok}, 8'h00);
		rd(ADDR_SE_MODE, v);
		check(v, 8'h00);
		addr_sel = 1'b1;
		wr(ADDR_SS0, 8'h85);
		check({2'b00, ss_cfg[0]}, 8'h25);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_SS1, SS_W[i]);
			check({2'b00, ss_cfg[1]}, SS_E[i]);
		end
		wr(ADDR_DIV_A, 8'h05);
		wr(ADDR_DIV_B, 8'hFF);
		check(div_n[0], DIV_MIN);
		fs_int = 5'h01;
		repeat (4) @(negedge mclk);
		check(div_n[0], 8'hFF);
		ref_sel = 2'b10;
		repeat (4) @(negedge mclk);
		check({6'h0, rsel}, 8'h02);
		wr(ADDR_REF_CFG, 8'h01);
		check({6'h0, rsel}, 8'h01);
		ref_sel = 2'b00;
		wr(ADDR_REF_CFG, RST_REF_CFG);
		check({6'h0, rsel}, 8'h00);
		for (int i = 0; i < N_OUT; i++) begin
			wr(ADDR_SKEW + 8'(i), 8'(7 - i));
			check({5'h0, skew[i]}, 8'(7 - i));
		end
		oe_low = 1'b1;
		out_chk(0, 1'b0, 1'b0);
		out_chk(1, 1'b0, 1'b0);
		oe_low = 1'b0;
		out_chk(0, 1'b1, 1'b0);
		wr(ADDR_OE_SCOPE, 8'h01);
		oe_low = 1'b1;
		out_chk(0, 1'b0, 1'b0);
		out_chk(1, 1'b1, 1'b0);
		oe_low = 1'b0;
		wr(ADDR_OUT_EN, 8'hFE);
		out_chk(0, 1'b0, 1'b0);
		out_chk(1, 1'b1, 1'b0);
		wr(ADDR_OUT_EN, 8'hFF);
		wr(ADDR_SE_MODE, 8'h02);
		out_chk(1, 1'b1, 1'b1);
		wr(ADDR_POL_COMP, 8'h02);
		out_chk(1, 1'b1, 1'b0);
		wr(ADDR_POL_TRUE, 8'h02);
		out_chk(1, 1'b1, 1'b1);
		do_reset();
		rd(ADDR_SE_MODE, v);
		check(v, RST_OTHER);
		wait_start();
		test_done();
	end
endmodule

bind coc_clock_output_control coc_checker #(.N_OUT(N_OUT), .N_DIV(N_DIV)) chk (
	.mclk_i(mclk_i), .rst_i(rst_i), .oclk_i(oclk_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o),
	.output_enable_low_pin_i(output_enable_low_pin_i),
	.spread_enable_pins_i(spread_enable_pins_i),
	.frac_synth_freq_select_i(frac_synth_freq_select_i),
	.profile_select_i(profile_select_i), .clk_out_true_pin_o(clk_out_true_pin_o),
	.clk_out_comp_pin_o(clk_out_comp_pin_o), .spread_enable_synth_o(spread_enable_synth_o),
	.spread_cfg_o(spread_cfg_o), .frac_synth_profile_o(frac_synth_profile_o),
	.integer_divider_n_o(integer_divider_n_o), .outputs_started_o(outputs_started_o),
	.profile_o(profile_o));
